/* cdseq_top.sv */
// Purpose: four-channel display sequencer, gating pairs 1&2 and 3&4
// Assumes: alternate sync is a one-cycle pulse per sweep end
// Notes:   mode selects mixed chop/alternate or alternate of added pairs
//
// Overview of operation
// - mixed: trigger driven by high-pair toggle
// - display toggle flips on each trigger
// - low pair shown: low gate on, high off
// - high pair shown: high gate on, low off
// - mixed order: chop 1&2 twice, 3, 4
// - low chop pulses become inverted blanking
// - added mode: sync shaper active, reshapes sync
// - added mode: low chop oscillator held, silent
// - added mode: low toggle both off, sum
// - added mode: high pair mirrors low pair
// - added mode: trigger once per shaped sync
// - mixed: low chop runs only on low pair
// - mixed: high toggle flips on each sync
`timescale 1ns/1ps
`default_nettype none
module cdseq_top
  import cdseq_pkg::*;
#(
  parameter int CHOP_CYC  = CDSEQ_CHOP_CYC,
  parameter int BLANK_CYC = CDSEQ_BLANK_CYC
) (
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  // mode and mainframe sync
  input  wire cdseq_mode_e i_mode,
  input  wire logic        i_alt_sync,
  // channel gates
  output logic             o_gate_ch1,
  output logic             o_gate_ch2,
  output logic             o_gate_ch3,
  output logic             o_gate_ch4,
  output logic             o_gate_low_pair,
  output logic             o_gate_high_pair,
  // blanking toward mainframe, active low
  output logic             o_blank_n
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire mode_mixed = (i_mode == CDSEQ_MODE_MIXED);
  wire mode_added = (i_mode == CDSEQ_MODE_ADDED);

  // ----------------------------------------------------------------
  // sync shaper and toggles
  // ----------------------------------------------------------------
  logic sync_shaper_input_q;
  logic sync_shaper_output_q;
  logic display_toggle_high_pair_side_q;
  logic low_pair_toggle_a_q;
  logic high_pair_toggle_output_q;
  logic display_trigger_oscillator;
  logic low_pair_chop_pulse;

  // shaper is a rising-edge detector so a long sync level counts once
  wire shaped_sync = sync_shaper_input_q && !sync_shaper_output_q;

  // high toggle flips per sync in mixed mode; trigger on its falling edge
  wire high_toggle_d = mode_mixed && i_alt_sync
                       ? !high_pair_toggle_output_q : high_pair_toggle_output_q;
  wire high_fall     = high_pair_toggle_output_q && !high_toggle_d;

  // display trigger source depends on mode
  assign display_trigger_oscillator =
      (mode_mixed && high_fall && i_alt_sync)
    | (mode_added && shaped_sync);

  // low pair chop runs only while low pair is displayed
  wire display_toggle_low_pair_side = !display_toggle_high_pair_side_q;
  wire low_pair_osc_hold = !(mode_mixed && display_toggle_low_pair_side);

  cdseq_chop_osc #(
    .PERIOD (CHOP_CYC)
  ) u_low_pair_chop_oscillator (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_q),
    .i_ce    (i_ce),
    .i_run   (!low_pair_osc_hold),
    .o_pulse (low_pair_chop_pulse)
  );

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sync_shaper_input_q             <= 1'b0;
      sync_shaper_output_q            <= 1'b0;
      display_toggle_high_pair_side_q <= CDSEQ_DISP_RST;
      low_pair_toggle_a_q             <= CDSEQ_LOW_RST;
      high_pair_toggle_output_q       <= CDSEQ_HIGH_RST;
    end else if (i_ce) begin
      sync_shaper_input_q       <= mode_added && i_alt_sync;
      sync_shaper_output_q      <= sync_shaper_input_q;
      high_pair_toggle_output_q <= high_toggle_d;
      if (display_trigger_oscillator) begin
        display_toggle_high_pair_side_q <= !display_toggle_high_pair_side_q;
      end
      if (low_pair_chop_pulse) begin
        low_pair_toggle_a_q <= !low_pair_toggle_a_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // gate decode
  // ----------------------------------------------------------------
  // in added mode both halves of each pair toggle are off: both gates on
  wire ch1_d  = mode_added || !low_pair_toggle_a_q;
  wire ch2_d  = mode_added || low_pair_toggle_a_q;
  wire ch3_d  = mode_added || !high_pair_toggle_output_q;
  wire ch4_d  = mode_added || high_pair_toggle_output_q;
  wire low_d  = display_toggle_low_pair_side;
  wire high_d = display_toggle_high_pair_side_q;

  // blanking stretch: each chop pulse gives a fixed low pulse
  localparam int BW = $clog2(BLANK_CYC + 1);
  logic [BW-1:0] blank_cnt_q;
  wire  [BW-1:0] blank_cnt_d = low_pair_chop_pulse ? BW'(BLANK_CYC) :
                               (blank_cnt_q != '0) ? blank_cnt_q - 1'b1 : blank_cnt_q;

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_gate_ch1       <= 1'b1;
      o_gate_ch2       <= 1'b0;
      o_gate_ch3       <= 1'b1;
      o_gate_ch4       <= 1'b0;
      o_gate_low_pair  <= 1'b1;
      o_gate_high_pair <= 1'b0;
      o_blank_n        <= 1'b1;
      blank_cnt_q      <= '0;
    end else if (i_ce) begin
      o_gate_ch1       <= ch1_d;
      o_gate_ch2       <= ch2_d;
      o_gate_ch3       <= ch3_d;
      o_gate_ch4       <= ch4_d;
      o_gate_low_pair  <= low_d;
      o_gate_high_pair <= high_d;
      blank_cnt_q      <= blank_cnt_d;
      o_blank_n        <= (blank_cnt_d == '0);
    end
  end
endmodule
`default_nettype wire

/* cdseq_pkg.sv */
// Purpose: shared constants for the channel display sequencer
// Assumes: one clock, synchronous inputs
// Notes:   chop period is a count of system clocks
package cdseq_pkg;
  // chop oscillator period in ns and derived cycle count at 5 ns clock
  localparam int CDSEQ_CLK_PERIOD_NS = 5;
  localparam int CDSEQ_CHOP_NS       = 2000;
  localparam int CDSEQ_CHOP_CYC      = (CDSEQ_CHOP_NS + CDSEQ_CLK_PERIOD_NS - 1)
                                       / CDSEQ_CLK_PERIOD_NS;
  // blanking pulse length in ns and derived cycle count
  localparam int CDSEQ_BLANK_NS      = 50;
  localparam int CDSEQ_BLANK_CYC     = (CDSEQ_BLANK_NS + CDSEQ_CLK_PERIOD_NS - 1)
                                       / CDSEQ_CLK_PERIOD_NS;
  // reset values of toggle stages
  localparam logic CDSEQ_DISP_RST    = 1'b0;  // 0 selects pair 1&2
  localparam logic CDSEQ_LOW_RST     = 1'b0;  // 0 shows channel 1
  localparam logic CDSEQ_HIGH_RST    = 1'b0;  // 0 shows channel 3
  // display mode encoding
  typedef enum logic [1:0] {
    CDSEQ_MODE_IDLE  = 2'b00,
    CDSEQ_MODE_MIXED = 2'b01,
    CDSEQ_MODE_ADDED = 2'b10
  } cdseq_mode_e;
endpackage

/* cdseq_chop_osc.sv */
// Purpose: free-running chop oscillator with hold input
// Assumes: i_run synchronous to i_clk
// Notes:   emits a one-cycle pulse every PERIOD cycles while running
`timescale 1ns/1ps
`default_nettype none
module cdseq_chop_osc #(
  parameter int PERIOD = 400
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // control
  input  wire logic i_run,
  // pulse out
  output logic      o_pulse
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] cnt_q;
  logic          pulse_q;
  wire           wrap = (cnt_q == LAST);

  // held means triggered state with no triggers: counter parked at zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else if (i_ce) begin
      cnt_q   <= (!i_run || wrap) ? '0 : cnt_q + 1'b1;
      pulse_q <= i_run && wrap;
    end
  end
  assign o_pulse = pulse_q;
endmodule
`default_nettype wire

/* cdseq_mainframe.sv */
// Purpose: mainframe stand-in: sweep-end sync source, blanking sink
// Assumes: sync is launched at the falling clock edge
// Notes:   counts blanking pulses so the bench can compare rates
`timescale 1ns/1ps
`default_nettype none
module cdseq_mainframe (
  input  wire logic i_clk,
  input  wire logic i_blank_n,
  output var logic  o_alt_sync,
  output var int    o_blanks
);
  initial o_alt_sync = 1'b0;
  initial o_blanks = 0;
  always @(negedge i_blank_n) o_blanks++;
  // one sweep end, then a low cycle since added mode needs a gap
  task automatic sweep();
    @(negedge i_clk) o_alt_sync = 1'b1;
    @(negedge i_clk) o_alt_sync = 1'b0;
    @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

/* cdseq_monitor.sv */
// Purpose: port checker for cdseq_top
// Assumes: blanking length of 2 cycles as set in the bench
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module cdseq_monitor
  import cdseq_pkg::*;
#(
  parameter int CHOP_CYC  = 8,
  parameter int BLANK_CYC = 2
) (
  input wire logic        i_clk,
  input wire logic        i_nrst,
  input wire logic        i_ce,
  input wire cdseq_mode_e i_mode,
  input wire logic        i_alt_sync,
  input wire logic        o_gate_ch1,
  input wire logic        o_gate_ch2,
  input wire logic        o_gate_ch3,
  input wire logic        o_gate_ch4,
  input wire logic        o_gate_low_pair,
  input wire logic        o_gate_high_pair,
  input wire logic        o_blank_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire mx = (i_mode == CDSEQ_MODE_MIXED) && i_ce;
  wire ad = (i_mode == CDSEQ_MODE_ADDED);
  pair_excl_a: assert property (o_gate_high_pair == !o_gate_low_pair)
    else $error("pair gates overlap");
  // toggles move on the sync edge, the registered gates one edge later
  high_flip_a: assert property (mx && i_alt_sync |=> ##1
    o_gate_ch3 != $past(o_gate_ch3) && o_gate_ch4 == !o_gate_ch3) else $error("ch3 ch4 flip");
  disp_half_a: assert property (mx && i_alt_sync && o_gate_ch4 |=> ##1
    o_gate_low_pair != $past(o_gate_low_pair)) else $error("display toggle missed");
  disp_hold_a: assert property (mx && i_alt_sync && o_gate_ch3 |=> ##1
    $stable(o_gate_low_pair)) else $error("display toggle early");
  chop_hold_a: assert property ((mx && o_gate_high_pair) [*4] |-> $stable(o_gate_ch1))
    else $error("chop ran on high pair");
  blank_len_a: assert property ($fell(o_blank_n) |-> !o_blank_n [*2] ##1 o_blank_n)
    else $error("blank length");
  blank_chop_a: assert property ($fell(o_blank_n) |=> o_gate_ch1 != $past(o_gate_ch1))
    else $error("blank without chop");
  add_sum_a: assert property (ad [*4] |-> o_gate_ch1 && o_gate_ch2 && o_gate_ch3
    && o_gate_ch4 && o_blank_n) else $error("added gates");
  add_flip_a: assert property (ad && $rose(i_alt_sync) |-> ##[2:4]
    (o_gate_low_pair != $past(o_gate_low_pair))) else $error("added toggle");
endmodule
bind cdseq_top cdseq_monitor #(.CHOP_CYC(CHOP_CYC), .BLANK_CYC(BLANK_CYC)) mon_u (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_mode(i_mode), .i_alt_sync(i_alt_sync),
  .o_gate_ch1(o_gate_ch1), .o_gate_ch2(o_gate_ch2), .o_gate_ch3(o_gate_ch3),
  .o_gate_ch4(o_gate_ch4), .o_gate_low_pair(o_gate_low_pair),
  .o_gate_high_pair(o_gate_high_pair), .o_blank_n(o_blank_n));
`default_nettype wire

/* channel_display_sequencer_tb.sv */
// Purpose: self-checking bench for cdseq_top
// Assumes: short chop and blank counts of 8 and 2
// Notes:   inputs move at the falling edge
`timescale 1ns/1ps
`default_nettype none
module channel_display_sequencer_tb;
  import cdseq_pkg::*;
  logic        i_clk  = 1'b0;
  logic        i_nrst = 1'b0;
  logic        ce     = 1'b1;
  cdseq_mode_e i_mode = CDSEQ_MODE_IDLE;
  logic        sync, c1, c2, c3, c4, lp, hp, blank_n;
  int          blanks, b, miscompares = 0, compares = 0;
  wire [5:0]   gates = {c1, c2, c3, c4, lp, hp};
  always #2.5 i_clk = ~i_clk;
  cdseq_top #(.CHOP_CYC(8), .BLANK_CYC(2)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_ce(ce), .i_mode(i_mode), .i_alt_sync(sync), .o_gate_ch1(c1), .o_gate_ch2(c2),
    .o_gate_ch3(c3), .o_gate_ch4(c4), .o_gate_low_pair(lp), .o_gate_high_pair(hp),
    .o_blank_n(blank_n));
  cdseq_mainframe mf_u (.i_clk(i_clk), .i_blank_n(blank_n), .o_alt_sync(sync),
    .o_blanks(blanks));
  task automatic check(string what, logic [5:0] exp, logic [5:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset();
    repeat (6) @(negedge i_clk);
    check("reset gates", 6'h2a, gates);
    i_nrst = 1'b1;
    repeat (3) @(negedge i_clk);
  endtask
  // syncs in idle must leave everything alone
  task automatic t_idle();
    mf_u.sweep();
    check("idle gates", 6'h2a, gates);
    check("idle blanks", 6'd0, 6'(blanks));
  endtask
  task automatic t_mixed();
    logic [3:0] exp [4] = '{4'h6, 4'h9, 4'h5, 4'ha};
    i_mode = CDSEQ_MODE_MIXED;
    repeat (40) @(negedge i_clk);
    b = blanks;
    repeat (32) @(negedge i_clk);
    check("chop blanks", 6'd4, 6'(blanks - b));
    check("ch1 ch2 split", 6'd1, {5'd0, c1 ^ c2});
    for (int i = 0; i < 4; i++) begin
      mf_u.sweep();
      check("pair gates", {2'b00, exp[i]}, {2'b00, gates[3:0]});
      // enable low freezes state: a sweep end must then be ignored
      if (i == 2) begin
        ce = 1'b0;
        mf_u.sweep();
        check("frozen gates", {2'b00, exp[i]}, {2'b00, gates[3:0]});
        ce = 1'b1;
      end
      if (i == 1) begin
        repeat (4) @(negedge i_clk);
        b = blanks;
        repeat (32) @(negedge i_clk);
        check("held blanks", 6'd0, 6'(blanks - b));
      end
    end
  endtask
  task automatic t_added();
    i_mode = CDSEQ_MODE_ADDED;
    repeat (6) @(negedge i_clk);
    b = blanks;
    check("sum gates", 6'h3e, gates);
    for (int i = 0; i < 2; i++) begin
      mf_u.sweep();
      repeat (2) @(negedge i_clk);
      check("added pair", (i == 0) ? 6'h3d : 6'h3e, gates);
    end
    check("added blanks", 6'd0, 6'(blanks - b));
  endtask
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    t_reset();
    t_idle();
    t_mixed();
    t_added();
    tally_and_finish();
  end
endmodule
`default_nettype wire
